// *** design/tfl_line_control.sv ***
// Line control of one T1 framer channel: registers, loop codes, density, sync skip
// Summary of operation
// - framing register bit 3 picks receive format
// - store reset only on zero-to-one edge
// - skip bit halves multiframe sync pulses
// - skip works only in multiframe sync mode
// - options bit 3 enables transmit enforcer
// - loop-down sends repeating 001
// - loop-up sends repeating 00001
// - framing bits override loop code pattern
// - loop code lasts while its bit set
// - flag more than fifteen consecutive zeros
// - flag windows 8(N+1) bits holding under N ones
// - tx violations bit 2, rx bit 1
// - enforcer forces compliant transmit stream
// - no control reset value may be trusted
`timescale 1ns/1ps
`default_nettype none
module tfl_line_control (
  input wire logic clk,                 // Control port clock
  input wire logic rst_n,               // Async reset, active low
  input wire logic [7:0] addr,          // Register address
  input wire logic [7:0] wdata,         // Write data
  input wire logic wr_en,               // Write strobe, one cycle
  input wire logic rd_en,               // Read strobe, one cycle
  output logic [7:0] rdata,             // Read data, one cycle after rd_en
  input wire logic [7:0] rx_control_two, // Receive control two contents
  input wire logic rx_sync_loss,        // Receive loss of sync from core
  input wire logic tx_clock_loss,       // Loss of transmit clock from core
  output logic loss_output_pin,         // Selected loss indication
  output logic store_depth_reset,       // Elastic store reset pulse
  output logic store_min_delay_sel,     // Elastic store minimum delay
  output logic tx_frame_format_sel,     // Transmit ESF when high
  output logic tx_zero_substitution_en, // Transmit B8ZS enable
  output logic tx_subscriber_carrier_insert_en, // Transmit SLC-96 insert
  output logic tx_datalink_zero_stuff_en,       // Transmit data-link stuffer
  output logic rx_frame_format_sel,     // Receive ESF when high
  output logic rx_zero_substitution_en, // Receive B8ZS enable
  output logic rx_subscriber_carrier_extract_en, // Receive SLC-96 extract
  output logic rx_datalink_zero_destuff_en,      // Receive data-link destuffer
  input wire logic link_clk,            // Line bit clock
  input wire logic tx_payload_bit,      // Normal transmit bit
  input wire logic tx_framing_bit,      // Framing bit value
  input wire logic tx_fbit_slot,        // This cycle is a framing bit slot
  input wire logic rx_line_bit,         // Received line bit
  input wire logic rx_sync_pulse_in,    // Receive sync pulse from core
  output logic tx_line_bit,             // Transmitted line bit
  output logic rx_sync_output           // Receive sync output pulse
);
  logic [7:0] line_options_control;
  logic [7:0] framing_coding_control;
  logic [1:0] rx_information_two; // {tx, rx} density flags
  logic [1:0] density_clear;
  logic esr_prev;
  logic skip_eff;
  logic [3:0] cfg_meta;
  logic [3:0] cfg_link;
  logic pde_l;
  logic ld_l;
  logic lu_l;
  logic skip_l;
  logic [1:0] viol_tog;
  logic [1:0] viol_s1;
  logic [1:0] viol_s2;
  logic [1:0] viol_s3;
  logic [1:0] viol_evt;
  logic [1:0] viol_pend; // Violations waiting for the crossing to free up
  logic [1:0] viol_want;
  logic [1:0] viol_idle;
  logic [1:0] viol_ack_s1;
  logic [1:0] viol_ack_s2;
  logic loop_bit;
  logic chosen_bit;
  logic next_tx_line_bit;
  logic sync_phase;

  tfl_mon_if tx_mon ();
  tfl_mon_if rx_mon ();

  // Control registers; reset values only keep simulation clean, never rely on them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_options_control <= tfl_pkg::RST_LINE_OPTIONS;
      framing_coding_control <= tfl_pkg::RST_FRAMING_CODING;
    end else if (wr_en) begin
      case (addr)
        tfl_pkg::OFF_LINE_OPTIONS: begin
          line_options_control <= wdata & tfl_pkg::LINE_OPTIONS_WMASK;
        end
        tfl_pkg::OFF_FRAMING_CODING: begin
          framing_coding_control <= wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Format and coding selects drive the framer core straight from the register
  assign tx_frame_format_sel = framing_coding_control[tfl_pkg::BIT_TX_FORMAT];
  assign tx_zero_substitution_en = framing_coding_control[tfl_pkg::BIT_TX_ZSUB];
  assign tx_subscriber_carrier_insert_en = framing_coding_control[tfl_pkg::BIT_TX_SLC];
  assign tx_datalink_zero_stuff_en = framing_coding_control[tfl_pkg::BIT_TX_STUFF];
  assign rx_frame_format_sel = framing_coding_control[tfl_pkg::BIT_RX_FORMAT];
  assign rx_zero_substitution_en = framing_coding_control[tfl_pkg::BIT_RX_ZSUB];
  assign rx_subscriber_carrier_extract_en = framing_coding_control[tfl_pkg::BIT_RX_SLC];
  assign rx_datalink_zero_destuff_en = framing_coding_control[tfl_pkg::BIT_RX_DESTUFF];
  assign store_min_delay_sel = line_options_control[tfl_pkg::BIT_MIN_DELAY];

  // Density flags are sticky; writing a one clears, a new event wins over the clear
  assign density_clear = (wr_en && addr == tfl_pkg::OFF_RX_INFO_TWO) ?
    wdata[tfl_pkg::BIT_DENSITY_LSB+1:tfl_pkg::BIT_DENSITY_LSB] : 2'b00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_information_two <= 2'b00;
    end else begin
      rx_information_two <= viol_evt | (rx_information_two & ~density_clear);
    end
  end

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        tfl_pkg::OFF_LINE_OPTIONS: rdata <= line_options_control;
        tfl_pkg::OFF_FRAMING_CODING: rdata <= framing_coding_control;
        tfl_pkg::OFF_RX_INFO_TWO: rdata <= {5'h00, rx_information_two, 1'b0};
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Only the rising edge resets the stores; holding the bit high does nothing more
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      esr_prev <= 1'b0;
      store_depth_reset <= 1'b0;
    end else begin
      esr_prev <= line_options_control[tfl_pkg::BIT_DEPTH_RESET];
      store_depth_reset <= line_options_control[tfl_pkg::BIT_DEPTH_RESET] && !esr_prev;
    end
  end

  // Loss pin function select; inputs come from the core on this clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_output_pin <= 1'b0;
    end else if (line_options_control[tfl_pkg::BIT_LOSS_SEL]) begin
      loss_output_pin <= tx_clock_loss;
    end else begin
      loss_output_pin <= rx_sync_loss;
    end
  end

  // Skip applies only when sync output is in multiframe mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_eff <= 1'b0;
    end else begin
      skip_eff <= line_options_control[tfl_pkg::BIT_SYNC_SKIP] &&
        rx_control_two[tfl_pkg::BIT_RCR_MF_ON] && !rx_control_two[tfl_pkg::BIT_RCR_MF_OFF];
    end
  end

  // Quasi-static levels into the link domain; a bit may land a cycle early or late
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_meta <= 4'h0;
      cfg_link <= 4'h0;
    end else begin
      cfg_meta <= {line_options_control[tfl_pkg::BIT_ENFORCER],
                   line_options_control[tfl_pkg::BIT_LOOP_DOWN],
                   line_options_control[tfl_pkg::BIT_LOOP_UP], skip_eff};
      cfg_link <= cfg_meta;
    end
  end
  assign {pde_l, ld_l, lu_l, skip_l} = cfg_link;

  tfl_loop_gen u_loop_gen (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .send_up(lu_l),
    .send_down(ld_l),
    .loop_bit(loop_bit)
  );

  // Framing slot first, then loop code, then payload
  always_comb begin
    if (tx_fbit_slot) begin
      chosen_bit = tx_framing_bit;
    end else if (lu_l || ld_l) begin
      chosen_bit = loop_bit;
    end else begin
      chosen_bit = tx_payload_bit;
    end
  end

  // Enforcer turns a zero into a one when the zero would break density
  assign next_tx_line_bit = chosen_bit || (pde_l && tx_mon.need_one);
  assign tx_mon.bit_in = next_tx_line_bit;
  assign rx_mon.bit_in = rx_line_bit;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_line_bit <= 1'b0;
    end else begin
      tx_line_bit <= next_tx_line_bit;
    end
  end

  // The transmit monitor sees the stream after the enforcer
  tfl_density_mon u_tx_mon (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .m(tx_mon)
  );

  tfl_density_mon u_rx_mon (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .m(rx_mon)
  );

  // Every other multiframe pulse is dropped while skipping
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_phase <= 1'b0;
      rx_sync_output <= 1'b0;
    end else begin
      if (!skip_l) begin
        sync_phase <= 1'b0;
      end else if (rx_sync_pulse_in) begin
        sync_phase <= !sync_phase;
      end
      rx_sync_output <= rx_sync_pulse_in && (!skip_l || !sync_phase);
    end
  end

  // Violations cross as toggles; ones that come while a toggle is in flight wait
  // in viol_pend, since two toggles inside one clk period would cancel out
  assign viol_want = viol_pend | {tx_mon.violation, rx_mon.violation};
  assign viol_idle = ~(viol_tog ^ viol_ack_s2);
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      viol_tog <= 2'b00;
      viol_pend <= 2'b00;
    end else begin
      viol_tog <= viol_tog ^ (viol_want & viol_idle);
      viol_pend <= viol_want & ~viol_idle;
    end
  end

  // Acknowledge brings the toggle seen on clk back to the line side
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      viol_ack_s1 <= 2'b00;
      viol_ack_s2 <= 2'b00;
    end else begin
      viol_ack_s1 <= viol_s2;
      viol_ack_s2 <= viol_ack_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      viol_s1 <= 2'b00;
      viol_s2 <= 2'b00;
      viol_s3 <= 2'b00;
    end else begin
      viol_s1 <= viol_tog;
      viol_s2 <= viol_s1;
      viol_s3 <= viol_s2;
    end
  end
  assign viol_evt = viol_s2 ^ viol_s3;

  sequence s_esr_rise;
    line_options_control[tfl_pkg::BIT_DEPTH_RESET] && !esr_prev;
  endsequence
  property p_esr_edge;
    @(posedge clk) disable iff (!rst_n) s_esr_rise |=> store_depth_reset ##1 !store_depth_reset;
  endproperty
  a_esr_edge: assert property (p_esr_edge) else $error("store reset pulse wrong");
  property p_esr_hold;
    @(posedge clk) disable iff (!rst_n)
      $past(line_options_control[tfl_pkg::BIT_DEPTH_RESET]) &&
      line_options_control[tfl_pkg::BIT_DEPTH_RESET] |=> !store_depth_reset;
  endproperty
  a_esr_hold: assert property (p_esr_hold) else $error("held store reset bit re-fired");
  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
      viol_evt[1] |=> rx_information_two[1];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("tx density flag not set");
  property p_flag_path;
    @(posedge link_clk) disable iff (!rst_n)
      rx_mon.violation |-> ##[1:20] rx_information_two[0];
  endproperty
  a_flag_path: assert property (p_flag_path) else $error("rx density flag not set");
  property p_flag_stick;
    @(posedge clk) disable iff (!rst_n)
      rx_information_two[0] && !density_clear[0] |=> rx_information_two[0];
  endproperty
  a_flag_stick: assert property (p_flag_stick) else $error("rx density flag lost");
  property p_fbit_wins;
    @(posedge link_clk) disable iff (!rst_n)
      tx_fbit_slot && !(pde_l && tx_mon.need_one) |=> tx_line_bit == $past(tx_framing_bit);
  endproperty
  a_fbit_wins: assert property (p_fbit_wins) else $error("framing bit not sent");
  property p_loop_sent;
    @(posedge link_clk) disable iff (!rst_n)
      !tx_fbit_slot && (lu_l || ld_l) && !pde_l |=> tx_line_bit == $past(loop_bit);
  endproperty
  a_loop_sent: assert property (p_loop_sent) else $error("loop code not sent");
  property p_enforce;
    @(posedge link_clk) disable iff (!rst_n) pde_l && tx_mon.need_one |=> tx_line_bit;
  endproperty
  a_enforce: assert property (p_enforce) else $error("enforcer let a zero pass");
  property p_skip_drop;
    @(posedge link_clk) disable iff (!rst_n)
      skip_l && rx_sync_pulse_in && sync_phase |=> !rx_sync_output && !sync_phase;
  endproperty
  a_skip_drop: assert property (p_skip_drop) else $error("skipped sync pulse sent");
  property p_no_skip;
    @(posedge link_clk) disable iff (!rst_n) !skip_l && rx_sync_pulse_in |=> rx_sync_output;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("sync pulse dropped");
  property p_loss_tx;
    @(posedge clk) disable iff (!rst_n)
      line_options_control[tfl_pkg::BIT_LOSS_SEL] |=> loss_output_pin == $past(tx_clock_loss);
  endproperty
  a_loss_tx: assert property (p_loss_tx) else $error("loss pin not clock loss");
  property p_loss_rx;
    @(posedge clk) disable iff (!rst_n)
      !line_options_control[tfl_pkg::BIT_LOSS_SEL] |=> loss_output_pin == $past(rx_sync_loss);
  endproperty
  a_loss_rx: assert property (p_loss_rx) else $error("loss pin not sync loss");
endmodule
`default_nettype wire

// *** shared/tfl_pkg.sv ***
// Constants and types shared by the T1 line-control block
package tfl_pkg;
  // Register offsets on the parallel control port
  localparam logic [7:0] OFF_LINE_OPTIONS = 8'h30;
  localparam logic [7:0] OFF_RX_INFO_TWO = 8'h31;
  localparam logic [7:0] OFF_FRAMING_CODING = 8'h38;
  // Values after reset; software must still write every register
  localparam logic [7:0] RST_LINE_OPTIONS = 8'h00;
  localparam logic [7:0] RST_FRAMING_CODING = 8'h00;
  // Unassigned low bit of the line options register never stores a one
  localparam logic [7:0] LINE_OPTIONS_WMASK = 8'hfe;
  // Line options register fields
  localparam int BIT_MIN_DELAY = 7;
  localparam int BIT_DEPTH_RESET = 6;
  localparam int BIT_LOSS_SEL = 5;
  localparam int BIT_SYNC_SKIP = 4;
  localparam int BIT_ENFORCER = 3;
  localparam int BIT_LOOP_DOWN = 2;
  localparam int BIT_LOOP_UP = 1;
  // Framing and coding register fields
  localparam int BIT_TX_FORMAT = 7;
  localparam int BIT_TX_ZSUB = 6;
  localparam int BIT_TX_SLC = 5;
  localparam int BIT_TX_STUFF = 4;
  localparam int BIT_RX_FORMAT = 3;
  localparam int BIT_RX_ZSUB = 2;
  localparam int BIT_RX_SLC = 1;
  localparam int BIT_RX_DESTUFF = 0;
  // Receive control two fields that select multiframe sync pulses
  localparam int BIT_RCR_MF_ON = 4;
  localparam int BIT_RCR_MF_OFF = 3;
  // Density flags in receive information two: rx at bit 1, tx at bit 2
  localparam int BIT_DENSITY_LSB = 1;
  // Density rules and loop codes
  localparam int ZERO_RUN_MAX = 15;
  localparam int DENSITY_MAX_N = 23;
  localparam int LOOP_UP_LEN = 5;
  localparam int LOOP_DOWN_LEN = 3;
  // Loop code generator states
  typedef enum logic [2:0] {
    LG_IDLE = 3'b001,
    LG_UP = 3'b010,
    LG_DOWN = 3'b100
  } tfl_loop_state_t;
endpackage

// *** shared/tfl_mon_if.sv ***
// Bit stream link between the line control and a density monitor
`timescale 1ns/1ps
`default_nettype none
interface tfl_mon_if;
  logic bit_in;    // Line bit of this cycle
  logic need_one;  // A zero now would break a density rule
  logic violation; // One-cycle pulse after a violating bit
  modport ctl (output bit_in, input need_one, input violation);
  modport mon (input bit_in, output need_one, output violation);
endinterface
`default_nettype wire

// *** design/tfl_loop_gen.sv ***
// Repeating loop-up and loop-down code generator
`timescale 1ns/1ps
`default_nettype none
module tfl_loop_gen (
  input wire logic link_clk, // Line bit clock
  input wire logic rst_n,    // Async reset, active low
  input wire logic send_up,  // Loop-up code requested
  input wire logic send_down, // Loop-down code requested
  output logic loop_bit      // Pattern bit of this cycle
);
  tfl_pkg::tfl_loop_state_t state;
  tfl_pkg::tfl_loop_state_t next_state;
  logic [2:0] phase;
  logic [2:0] last_phase;

  // Up wins if both are set, which software must never do
  always_comb begin
    next_state = tfl_pkg::LG_IDLE;
    if (send_up) begin
      next_state = tfl_pkg::LG_UP;
    end else if (send_down) begin
      next_state = tfl_pkg::LG_DOWN;
    end
  end

  always_comb begin
    case (state)
      tfl_pkg::LG_UP: last_phase = 3'(tfl_pkg::LOOP_UP_LEN - 1);
      tfl_pkg::LG_DOWN: last_phase = 3'(tfl_pkg::LOOP_DOWN_LEN - 1);
      default: last_phase = 3'h0;
    endcase
  end

  // Pattern runs on as long as the code stays selected
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= tfl_pkg::LG_IDLE;
      phase <= 3'h0;
    end else begin
      state <= next_state;
      if (next_state != state || phase == last_phase) begin
        phase <= 3'h0;
      end else begin
        phase <= phase + 3'h1;
      end
    end
  end

  // Zeros with a single one closing each period
  assign loop_bit = (state != tfl_pkg::LG_IDLE) && (phase == last_phase);

  sequence s_up_ones;
    (state == tfl_pkg::LG_UP && loop_bit) ##1 (state == tfl_pkg::LG_UP)[*5];
  endsequence
  property p_up_period;
    @(posedge link_clk) disable iff (!rst_n) s_up_ones |-> loop_bit;
  endproperty
  a_up_period: assert property (p_up_period) else $error("loop-up period not five");
  property p_down_period;
    @(posedge link_clk) disable iff (!rst_n)
      (state == tfl_pkg::LG_DOWN && loop_bit) ##1 (state == tfl_pkg::LG_DOWN)[*3] |-> loop_bit;
  endproperty
  a_down_period: assert property (p_down_period) else $error("loop-down period not three");
endmodule
`default_nettype wire

// *** design/tfl_density_mon.sv ***
// Ones-density monitor for one line bit stream
`timescale 1ns/1ps
`default_nettype none
module tfl_density_mon #(
  parameter int MAX_N = tfl_pkg::DENSITY_MAX_N,
  parameter int RUN_MAX = tfl_pkg::ZERO_RUN_MAX
) (
  input wire logic link_clk, // Line bit clock
  input wire logic rst_n,    // Async reset, active low
  tfl_mon_if.mon m           // Stream in, verdicts out
);
  localparam int WIN = 8 * (MAX_N + 1);
  logic [WIN-1:0] hist;
  logic [7:0] fill;
  logic [4:0] zero_run;
  logic [MAX_N:1] short_n;
  logic need_one;

  // History of line bits, newest at bit 0; windows count only once full
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist <= '0;
      fill <= 8'h00;
    end else begin
      hist <= {hist[WIN-2:0], m.bit_in};
      if (fill != 8'(WIN)) begin
        fill <= fill + 8'h01;
      end
    end
  end

  // Saturates at the limit so a long run keeps violating
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_run <= 5'h00;
    end else if (m.bit_in) begin
      zero_run <= 5'h00;
    end else if (zero_run < 5'(RUN_MAX)) begin
      zero_run <= zero_run + 5'h01;
    end
  end

  // One running count per window length; short means a zero now fails it
  genvar n;
  for (n = 1; n <= MAX_N; n++) begin : g_win
    localparam int LEN = 8 * (n + 1);
    logic [7:0] cnt;
    logic [7:0] prior;
    assign prior = cnt - {7'h00, hist[LEN-1]};
    assign short_n[n] = (fill >= 8'(LEN - 1)) && (prior < 8'(n));
    always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= 8'h00;
      end else begin
        cnt <= prior + {7'h00, m.bit_in};
      end
    end
  end

  assign need_one = (zero_run == 5'(RUN_MAX)) || (|short_n);
  assign m.need_one = need_one;

  // Checked on every bit, enforcer or not
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      m.violation <= 1'b0;
    end else begin
      m.violation <= !m.bit_in && need_one;
    end
  end

  property p_run_viol;
    @(posedge link_clk) disable iff (!rst_n)
      (zero_run == 5'(RUN_MAX) && !m.bit_in) |=> m.violation;
  endproperty
  a_run_viol: assert property (p_run_viol) else $error("sixteenth zero not flagged");
  property p_viol_cause;
    @(posedge link_clk) disable iff (!rst_n)
      m.violation |-> !$past(m.bit_in) && ($past(zero_run) == 5'(RUN_MAX) || |$past(short_n));
  endproperty
  a_viol_cause: assert property (p_viol_cause) else $error("violation without cause");
endmodule
`default_nettype wire

// *** tb/tfl_line_model.sv ***
// Line side stand-in: bit streams and sync pulses on the line clock
`timescale 1ns/1ps
`default_nettype none
module tfl_line_model (
  input wire logic link_clk, // Line bit clock
  input wire logic rst_n, // Async reset, active low
  input wire logic quiet, // All-zero payload and receive data
  output logic tx_payload_bit, // Payload toward the block
  output logic tx_framing_bit, // Framing bit value
  output logic tx_fbit_slot, // Framing slot marker
  output logic rx_line_bit, // Received line bit
  output logic rx_sync_pulse_in // Multiframe pulse every 12 bits
);
  int cnt;
  logic fb;
  // New bit values just after each line edge; framing slots only while quiet,
  // so loop code periods show whole and framing ones alternate with zeros
  always @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt = 0;
      fb = 1'b0;
      {tx_payload_bit, tx_framing_bit, tx_fbit_slot, rx_line_bit, rx_sync_pulse_in} = 5'h00;
    end else begin
      #1;
      cnt = (cnt == 11) ? 0 : cnt + 1;
      rx_sync_pulse_in = (cnt == 0);
      tx_payload_bit = quiet ? 1'b0 : 1'($urandom);
      rx_line_bit = quiet ? 1'b0 : 1'($urandom);
      tx_fbit_slot = quiet && (cnt == 6);
      if (tx_fbit_slot) fb = !fb;
      tx_framing_bit = quiet ? fb : 1'($urandom);
    end
  end
endmodule
`default_nettype wire

// *** tb/tfl_line_control_bench.sv ***
// Self-checking bench for the T1 line control block
`timescale 1ns/1ps
`default_nettype none
module tfl_line_control_bench;
  logic clk = 0, link_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, rd_d = 0, quiet = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx_control_two = 8'h00, v;
  logic rx_sync_loss = 0, tx_clock_loss = 0, loss_output_pin, store_depth_reset;
  logic store_min_delay_sel, tx_frame_format_sel, tx_zero_substitution_en;
  logic tx_subscriber_carrier_insert_en, tx_datalink_zero_stuff_en, rx_frame_format_sel;
  logic rx_zero_substitution_en, rx_subscriber_carrier_extract_en;
  logic rx_datalink_zero_destuff_en, tx_payload_bit, tx_framing_bit, tx_fbit_slot;
  logic rx_line_bit, rx_sync_pulse_in, tx_line_bit, rx_sync_output;
  logic [7:0] q[$];
  int err_count = 0, total_checks = 0, rst_cnt = 0, n;
  wire [7:0] fcc = {tx_frame_format_sel, tx_zero_substitution_en,
    tx_subscriber_carrier_insert_en, tx_datalink_zero_stuff_en, rx_frame_format_sel,
    rx_zero_substitution_en, rx_subscriber_carrier_extract_en, rx_datalink_zero_destuff_en};
  tfl_line_control dut_u (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .rx_control_two, .rx_sync_loss, .tx_clock_loss, .loss_output_pin, .store_depth_reset,
    .store_min_delay_sel, .tx_frame_format_sel, .tx_zero_substitution_en,
    .tx_subscriber_carrier_insert_en, .tx_datalink_zero_stuff_en, .rx_frame_format_sel,
    .rx_zero_substitution_en, .rx_subscriber_carrier_extract_en,
    .rx_datalink_zero_destuff_en, .link_clk, .tx_payload_bit, .tx_framing_bit,
    .tx_fbit_slot, .rx_line_bit, .rx_sync_pulse_in, .tx_line_bit, .rx_sync_output);
  tfl_line_model mdl_u (.link_clk, .rst_n, .quiet, .tx_payload_bit, .tx_framing_bit,
    .tx_fbit_slot, .rx_line_bit, .rx_sync_pulse_in);
  // Two unrelated clocks: 50 ns control, 30 ns line
  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One-cycle strobes, held across exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 {wr_en, addr, wdata} = {1'b1, a, d};
    @(posedge clk);
    #2 wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #2 {rd_en, addr} = {1'b1, a};
    q.push_back(e);
    @(posedge clk);
    #2 rd_en = 0;
  endtask
  task automatic lwait(input int k);
    repeat (k) @(posedge link_clk);
  endtask
  // Two consecutive periods must match and hold a single one each
  task automatic loop_chk(input int len);
    logic [7:0] a, b;
    a = 8'h00;
    b = 8'h00;
    for (int i = 0; i < 2 * len; i++) begin
      @(posedge link_clk);
      #1;
      if (i < len) a[i] = tx_line_bit;
      else b[i - len] = tx_line_bit;
    end
    chk("loop period", b, a);
    chk("loop ones", 8'($countones(a)), 8'h01);
  endtask
  // Read results arrive the cycle after the strobe; oldest note is compared
  always @(posedge clk) begin
    if (rd_d) chk("rdata", rdata, q.pop_front());
    rd_d <= rd_en;
    if (store_depth_reset === 1'b1) rst_cnt++;
  end
  // Loss inputs toggle at random so the selector sees traffic
  always @(posedge clk) #2 {rx_sync_loss, tx_clock_loss} = 2'($urandom);
  // Hang guard, far beyond the planned run
  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] ctl [3] = '{8'h10, 8'h18, 8'h10};
    logic [7:0] opt [3] = '{8'h10, 8'h10, 8'h00};
    logic [7:0] cnt [3] = '{8'h02, 8'h04, 8'h04};
    void'($urandom(32'h26f1b169));
    repeat (3) @(posedge clk);
    #2 rst_n = 1;
    wr(8'h30, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(8'h38, v);
      rd(8'h38, v);
      chk("format pins", fcc, v);
      // Options: bit 0, both loop bits and store reset stay clear; loss select alternates
      v = {1'($urandom), 1'b0, i[0], 2'($urandom), 3'h0};
      wr(8'h30, v);
      rd(8'h30, v);
      chk("min delay", {7'h00, store_min_delay_sel}, {7'h00, v[7]});
      @(posedge clk);
      #1 v[0] = v[5] ? tx_clock_loss : rx_sync_loss;
      chk("loss pin", {7'h00, loss_output_pin}, {7'h00, v[0]});
    end
    rd(8'h3f, 8'h00);
    // Store reset: held bit gives nothing, clear then set gives a second pulse
    wr(8'h30, 8'h40);
    wr(8'h30, 8'h40);
    wr(8'h30, 8'h00);
    wr(8'h30, 8'h40);
    repeat (3) @(posedge clk);
    chk("reset pulses", 8'(rst_cnt), 8'h02);
    wr(8'h30, 8'h02);
    lwait(8);
    loop_chk(5);
    wr(8'h30, 8'h04);
    lwait(8);
    loop_chk(3);
    loop_chk(3);
    // Zero streams: receive flag sets; transmit stays dense under loop-up, then the enforcer, and flags with neither
    wr(8'h30, 8'h02);
    wr(8'h38, 8'h00);
    wr(8'h31, 8'h06);
    quiet = 1;
    lwait(40);
    rd(8'h31, 8'h02);
    wr(8'h30, 8'h08);
    lwait(30);
    wr(8'h31, 8'h06);
    lwait(40);
    rd(8'h31, 8'h02);
    wr(8'h30, 8'h00);
    lwait(60);
    rd(8'h31, 8'h06);
    quiet = 0;
    // Sync pulses over four multiframes for each mode
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      #2 rx_control_two = ctl[k];
      wr(8'h30, opt[k]);
      lwait(6);
      n = 0;
      repeat (48) begin
        @(posedge link_clk);
        #1 n += rx_sync_output;
      end
      chk("sync pulses", 8'(n), cnt[k]);
    end
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
